// File: include/fal_defines.svh
// register offsets, reset values and timing counts of the flow alarm unit
`ifndef FAL_DEFINES_SVH
`define FAL_DEFINES_SVH
// -----------------------------------------------------------------
// global register offsets (byte addresses)
// -----------------------------------------------------------------
`define FAL_CTRL 8'h00
`define FAL_MANUAL 8'h04
`define FAL_STATUS 8'h08
`define FAL_MINV 8'h0C
`define FAL_MAXV 8'h10
`define FAL_VOL 8'h14
// -----------------------------------------------------------------
// per channel window: addr[7:6]=base, addr[5:4]=channel, addr[3:2]=reg
// -----------------------------------------------------------------
`define FAL_CH_BASE 2'h1
`define FAL_CH_CFG 2'h0
`define FAL_CH_SP 2'h1
`define FAL_CH_HY 2'h2
`define FAL_CH_TM 2'h3
`define FAL_TM2_LSB 16
// -----------------------------------------------------------------
// reset values and limits
// -----------------------------------------------------------------
`define FAL_CTRL_RST 8'h00
`define FAL_TMAX 16'h7D00
// -----------------------------------------------------------------
// timebase: one second at a 40 MHz clock
// -----------------------------------------------------------------
`define FAL_TICK_MS 1000
`define FAL_CLK_KHZ 40000
`endif

// File: include/fal_pkg.sv
// types shared by the flow alarm unit
package fal_pkg;
  // alarm functions
  typedef enum logic [2:0] {FN_OFF = 3'h0, FN_OPEN = 3'h1, FN_UNDER = 3'h2,
                            FN_OVER = 3'h3, FN_BATCH = 3'h4} fal_fn_t;
  // key / digital input actions
  typedef enum logic [1:0] {ACT_TOT = 2'h0, ACT_FRZ = 2'h1, ACT_MM = 2'h2,
                            ACT_BATCH = 2'h3} fal_act_t;
  // batch process states
  typedef enum logic [1:0] {B_IDLE = 2'h0, B_RUN = 2'h1, B_HOLD = 2'h2,
                            B_DONE = 2'h3} fal_bst_t;
  // timer phases
  typedef enum logic [1:0] {TM_IDLE = 2'h0, TM_WAIT = 2'h1, TM_ON = 2'h2,
                            TM_OFF = 2'h3} fal_tph_t;
  // control register layout
  typedef struct packed {
    logic rsv; // spare bit, keeps the word at eight bits
    logic loop_aux;
    logic loop_flow;
    logic manual;
    fal_act_t di_act;
    fal_act_t key_act;
  } fal_ctrl_t;
  // one alarm channel configuration
  typedef struct packed {
    fal_fn_t fn;
    logic blk;
    logic [15:0] sp;
    logic [15:0] hy;
    logic [15:0] t1;
    logic [15:0] t2;
  } fal_cfg_t;
  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } fal_bus_t;
  // timer state
  typedef struct packed {
    fal_tph_t ph;
    logic [15:0] cnt;
    logic on;
  } fal_tm_t;
endpackage

// File: core/fal_alarm_timer.sv
// delay / pulse / oscillator timer driving one alarm relay
`timescale 1ns/1ps
module fal_alarm_timer
  import fal_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cond,
  input wire logic tick,
  input wire logic [15:0] t1,
  input wire logic [15:0] t2,
  output logic relay
);
  fal_tm_t s_r; // whole timer state
  fal_tm_t s_nxt; // next state
  logic [16:0] inc; // count plus one, widened for compare

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    inc = {1'b0, s_r.cnt} + 17'h00001;
    if (!cond)
    begin
      // condition gone: everything restarts
      s_nxt.ph = TM_IDLE;
      s_nxt.cnt = 16'h0000;
      s_nxt.on = 1'b0;
    end
    else if (t1 == 16'h0000 && t2 == 16'h0000)
    begin
      // plain follower
      s_nxt.ph = TM_IDLE;
      s_nxt.on = 1'b1;
    end
    else
    begin
      case (s_r.ph)
        TM_IDLE:
        begin
          s_nxt.cnt = 16'h0000;
          // delay starts off, pulse and oscillator start on
          s_nxt.ph = (t1 == 16'h0000) ? TM_WAIT : TM_ON;
          s_nxt.on = (t1 != 16'h0000);
        end
        TM_WAIT:
        begin
          if (tick)
          begin
            // delay elapsed: relay stays on afterwards
            if (inc >= {1'b0, t2})
            begin
              s_nxt.ph = TM_ON;
              s_nxt.on = 1'b1;
              s_nxt.cnt = 16'h0000;
            end
            else
              s_nxt.cnt = inc[15:0];
          end
        end
        TM_ON:
        begin
          if (tick && t1 != 16'h0000)
          begin
            // on time over
            if (inc >= {1'b0, t1})
            begin
              s_nxt.ph = TM_OFF;
              s_nxt.on = 1'b0;
              s_nxt.cnt = 16'h0000;
            end
            else
              s_nxt.cnt = inc[15:0];
          end
        end
        TM_OFF:
        begin
          // single pulse parks here; oscillator turns back on
          if (tick && t2 != 16'h0000)
          begin
            if (inc >= {1'b0, t2})
            begin
              s_nxt.ph = TM_ON;
              s_nxt.on = 1'b1;
              s_nxt.cnt = 16'h0000;
            end
            else
              s_nxt.cnt = inc[15:0];
          end
        end
        default:
          s_nxt.ph = TM_IDLE;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign relay = s_r.on; // from a flop

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_direct_follow:
    assert property (cond && t1 == 16'h0000 && t2 == 16'h0000 |=> relay)
    else $error("relay not following condition");
  a_clear_restart:
    assert property (!cond |=> !relay && s_r.ph == TM_IDLE && s_r.cnt == 16'h0000)
    else $error("timer not restarted on clear");
  a_pulse_once:
    assert property (cond && s_r.ph == TM_OFF && t1 != 16'h0000 && t2 == 16'h0000
                     && $stable(t2) |=> !relay)
    else $error("single pulse repeated");
  a_osc_reon:
    assert property (cond && s_r.ph == TM_OFF && tick && t2 != 16'h0000
                     && inc >= {1'b0, t2} |=> relay)
    else $error("oscillator did not turn on");
endmodule // fal_alarm_timer

// File: core/fal_top.sv
// alarm evaluation, min/max, batch feeder and register port of the flow meter
// Operation
// - alarm is off, open, under, over or batch
// - compare instantaneous flow only, never totals
// - aux loop input feeds open-sensor alarm only
// - open-sensor alarm only with loop input
// - under-limit asserts while flow below setpoint
// - over-limit asserts while flow above setpoint
// - two timer values, 0 to 32000 seconds
// - both zero: relay follows condition directly
// - delay or single pulse from timer pair
// - both nonzero: relay oscillates on then off
// - light shows condition regardless of relay timer
// - each alarm has its own hysteresis band
// - initial blocking hides alarm present at power-up; channels reset to off and arm one cycle after reset, so blk hides nothing
// - blocking never applies to open-sensor alarm
// - track min and max flow, clearable
// - key and input each pick one action
// - activation when idle starts batch, relays on
// - activation while running holds batch, relays off
// - setpoint reached ends batch, relays off
// - activation after end restarts with cleared counters
// - batch setpoint locked while batch in progress
// - optionally restore batch state at power-up
// - manual mode drives outputs, then returns
// - two channels, up to four, each lit
// - pulse counter cleared at batch end, totalizer reset by key or input
`timescale 1ns/1ps
`include "fal_defines.svh"
module fal_top
  import fal_pkg::*;
#(
  parameter int NCH = 2, // fitted channels, 2 or 4
  parameter int TICK_CYCLES = `FAL_TICK_MS * `FAL_CLK_KHZ // clocks per second
)
(
  input wire logic clk,
  input wire logic rst,
  input fal_bus_t bus,
  output logic [31:0] rdata,
  input wire logic [15:0] flow,
  input wire logic flow_valid,
  input wire logic loop_open,
  input wire logic key_pin,
  input wire logic di_pin,
  input wire logic batch_reset_on_power,
  input fal_bst_t saved_bst,
  input wire logic [31:0] saved_vol,
  output logic [3:0] relay,
  output logic [3:0] light,
  output fal_bst_t batch_state,
  output logic [31:0] batch_vol,
  output logic freeze,
  output logic tot_clr,
  output logic pcnt_clr
);
  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    fal_cfg_t [3:0] cfg; // channel setup
    fal_ctrl_t ctrl; // control bits
    logic [3:0] man; // manual relay values
    logic [3:0] act; // hysteresis latch
    logic [3:0] armed; // seen a non-alarm since power-up
    logic [3:0] light; // alarm condition
    logic [3:0] relay; // relay drive
    logic [15:0] mn; // minimum flow
    logic [15:0] mx; // maximum flow
    logic mm_ok; // min/max hold a sample
    logic [2:0] ks; // key synchroniser
    logic [2:0] ds; // input synchroniser
    logic kf; // filtered key level
    logic df; // filtered input level
    fal_bst_t bst; // batch state
    logic [31:0] vol; // batch volume counter
    logic [25:0] tcnt; // timebase divider
    logic tick; // one-second strobe
    logic init; // power-up restore done
    logic frz; // display freeze
    logic tclr; // totalizer clear pulse
    logic pcc; // pulse counter clear pulse
    logic [31:0] rdata; // read answer
  } fal_st_t;

  localparam logic [25:0] TCMAX = 26'(TICK_CYCLES - 1); // last divider count

  fal_st_t s_r; // registered state
  fal_st_t s_nxt; // next state
  logic [3:0] tmr; // timer relay outputs
  logic kev; // key press edge
  logic dev; // input closure edge
  logic bev; // batch activation
  logic mmclr; // min/max clear
  logic reach; // batch setpoint reached
  logic [1:0] bch; // batch channel index
  logic bfound; // a batch channel exists

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // key or input assigned to this action fired
  function automatic logic hit(input fal_act_t a, input logic k, input logic d,
                               input fal_ctrl_t c);
    hit = (k && c.key_act == a) || (d && c.di_act == a);
  endfunction

  // clamp a timer write into the legal range
  function automatic logic [15:0] tsat(input logic [15:0] v);
    tsat = (v > `FAL_TMAX) ? `FAL_TMAX : v;
  endfunction

  // -----------------------------------------------------------------
  // activations: edge of the filtered level
  // -----------------------------------------------------------------
  // filter needs the second and third stage to agree
  assign kev = (s_r.ks[1] == s_r.ks[2]) && s_r.ks[2] && !s_r.kf;
  assign dev = (s_r.ds[1] == s_r.ds[2]) && s_r.ds[2] && !s_r.df;
  assign bev = hit(ACT_BATCH, kev, dev, s_r.ctrl);
  assign mmclr = hit(ACT_MM, kev, dev, s_r.ctrl);

  // -----------------------------------------------------------------
  // batch channel lookup and end test
  // -----------------------------------------------------------------
  always_comb
  begin
    bch = 2'h0;
    bfound = 1'b0;
    // lowest fitted batch channel owns the setpoint
    for (int i = 3; i >= 0; i--)
    begin
      if (i < NCH && s_r.cfg[i].fn == FN_BATCH)
      begin
        bch = 2'(i);
        bfound = 1'b1;
      end
    end
    // batch counter, not the totalizer, reaches the setpoint
    reach = bfound && (s_r.vol >= {16'h0000, s_r.cfg[bch].sp});
  end

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb
  begin
    logic [16:0] hi; // release point of under-limit
    logic [15:0] lo; // release point of over-limit
    logic on; // raw assert test
    logic off; // raw release test
    logic c; // channel condition
    hi = 17'h00000;
    lo = 16'h0000;
    on = 1'b0;
    off = 1'b0;
    c = 1'b0;
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    s_nxt.tclr = 1'b0;
    s_nxt.pcc = 1'b0;
    s_nxt.rdata = 32'h00000000;

    // one-second timebase
    if (s_r.tcnt >= TCMAX)
    begin
      s_nxt.tcnt = 26'h0000000;
      s_nxt.tick = 1'b1;
    end
    else
      s_nxt.tcnt = s_r.tcnt + 26'h0000001;

    // pin synchronisers; stage 0 feeds stage 1 only
    s_nxt.ks = {s_r.ks[1:0], key_pin};
    s_nxt.ds = {s_r.ds[1:0], di_pin};
    if (s_r.ks[1] == s_r.ks[2])
      s_nxt.kf = s_r.ks[2];
    if (s_r.ds[1] == s_r.ds[2])
      s_nxt.df = s_r.ds[2];

    // other key actions
    if (hit(ACT_TOT, kev, dev, s_r.ctrl))
    begin
      s_nxt.tclr = 1'b1;
      s_nxt.pcc = 1'b1;
    end
    if (hit(ACT_FRZ, kev, dev, s_r.ctrl))
      s_nxt.frz = !s_r.frz;

    // min/max tracking
    if (mmclr)
    begin
      s_nxt.mn = 16'h0000;
      s_nxt.mx = 16'h0000;
      s_nxt.mm_ok = 1'b0;
    end
    else if (flow_valid)
    begin
      // first sample after a clear seeds both
      if (!s_r.mm_ok || flow < s_r.mn)
        s_nxt.mn = flow;
      if (!s_r.mm_ok || flow > s_r.mx)
        s_nxt.mx = flow;
      s_nxt.mm_ok = 1'b1;
    end

    // batch feeder
    case (s_r.bst)
      B_IDLE, B_DONE:
      begin
        // start, or restart with cleared counters
        if (bev)
        begin
          s_nxt.bst = B_RUN;
          s_nxt.vol = 32'h00000000;
        end
      end
      B_RUN:
      begin
        if (bev)
          s_nxt.bst = B_HOLD;
        else if (reach)
        begin
          // values freeze, counter clears
          s_nxt.bst = B_DONE;
          s_nxt.pcc = 1'b1;
        end
        else if (s_r.tick)
          s_nxt.vol = s_r.vol + {16'h0000, flow}; // integrate per second
      end
      B_HOLD:
      begin
        // resume where it stopped
        if (bev)
          s_nxt.bst = B_RUN;
      end
      default:
        s_nxt.bst = B_IDLE;
    endcase

    // one-time restore after power returns
    if (!s_r.init)
    begin
      s_nxt.init = 1'b1;
      if (!batch_reset_on_power)
      begin
        s_nxt.bst = saved_bst;
        s_nxt.vol = saved_vol;
      end
    end

    // alarm channels
    for (int i = 0; i < 4; i++)
    begin
      hi = {1'b0, s_r.cfg[i].sp} + {1'b0, s_r.cfg[i].hy};
      lo = (s_r.cfg[i].hy > s_r.cfg[i].sp) ? 16'h0000 : s_r.cfg[i].sp - s_r.cfg[i].hy;
      on = 1'b0;
      off = 1'b0;
      c = 1'b0;
      case (s_r.cfg[i].fn)
        FN_UNDER:
        begin
          on = flow < s_r.cfg[i].sp;
          off = {1'b0, flow} > hi;
        end
        FN_OVER:
        begin
          on = flow > s_r.cfg[i].sp;
          off = flow < lo;
        end
        default:
        begin
          on = 1'b0;
          off = 1'b1;
        end
      endcase
      // latch between assert and release points
      if (s_r.act[i] && off)
        s_nxt.act[i] = 1'b0;
      else if (!s_r.act[i] && on)
        s_nxt.act[i] = 1'b1;
      // any non-alarm moment arms the channel
      if (!s_nxt.act[i])
        s_nxt.armed[i] = 1'b1;
      case (s_r.cfg[i].fn)
        // loop, as flow or as aux input, is the only source
        FN_OPEN: c = loop_open && (s_r.ctrl.loop_flow || s_r.ctrl.loop_aux);
        FN_BATCH: c = s_nxt.bst == B_RUN;
        FN_UNDER, FN_OVER: c = s_nxt.act[i] && (!s_r.cfg[i].blk || s_r.armed[i]);
        default: c = 1'b0;
      endcase
      // unfitted channels stay dark
      s_nxt.light[i] = (i < NCH) && c;
      if (s_r.ctrl.manual)
        s_nxt.relay[i] = s_r.man[i];
      else if (s_r.cfg[i].fn == FN_BATCH)
        s_nxt.relay[i] = (i < NCH) && s_nxt.bst == B_RUN;
      else
        s_nxt.relay[i] = (i < NCH) && tmr[i];
    end

    // register writes
    if (bus.wr)
    begin
      if (bus.addr[7:6] == `FAL_CH_BASE)
      begin
        case (bus.addr[3:2])
          `FAL_CH_CFG:
          begin
            s_nxt.cfg[bus.addr[5:4]].fn = fal_fn_t'(bus.wdata[2:0]);
            s_nxt.cfg[bus.addr[5:4]].blk = bus.wdata[3];
          end
          `FAL_CH_SP:
          begin
            // locked while a batch runs or holds
            if (!(s_r.cfg[bus.addr[5:4]].fn == FN_BATCH &&
                  (s_r.bst == B_RUN || s_r.bst == B_HOLD)))
              s_nxt.cfg[bus.addr[5:4]].sp = bus.wdata[15:0];
          end
          `FAL_CH_HY: s_nxt.cfg[bus.addr[5:4]].hy = bus.wdata[15:0];
          default:
          begin
            // out-of-range times clamp rather than wrap
            s_nxt.cfg[bus.addr[5:4]].t1 = tsat(bus.wdata[15:0]);
            s_nxt.cfg[bus.addr[5:4]].t2 = tsat(bus.wdata[31:`FAL_TM2_LSB]);
          end
        endcase
      end
      else if (bus.addr == `FAL_CTRL)
        s_nxt.ctrl = bus.wdata[7:0];
      else if (bus.addr == `FAL_MANUAL)
        s_nxt.man = bus.wdata[3:0];
    end

    // register reads; unmapped reads give zero
    if (bus.rd)
    begin
      if (bus.addr[7:6] == `FAL_CH_BASE)
      begin
        case (bus.addr[3:2])
          `FAL_CH_CFG:
            s_nxt.rdata = {28'h0000000, s_r.cfg[bus.addr[5:4]].blk,
                           s_r.cfg[bus.addr[5:4]].fn};
          `FAL_CH_SP: s_nxt.rdata = {16'h0000, s_r.cfg[bus.addr[5:4]].sp};
          `FAL_CH_HY: s_nxt.rdata = {16'h0000, s_r.cfg[bus.addr[5:4]].hy};
          default:
            s_nxt.rdata = {s_r.cfg[bus.addr[5:4]].t2, s_r.cfg[bus.addr[5:4]].t1};
        endcase
      end
      else
      begin
        case (bus.addr)
          `FAL_CTRL: s_nxt.rdata = {24'h000000, s_r.ctrl};
          `FAL_MANUAL: s_nxt.rdata = {28'h0000000, s_r.man};
          `FAL_STATUS: s_nxt.rdata = {22'h000000, s_r.bst, s_r.relay, s_r.light};
          `FAL_MINV: s_nxt.rdata = {16'h0000, s_r.mn};
          `FAL_MAXV: s_nxt.rdata = {16'h0000, s_r.mx};
          `FAL_VOL: s_nxt.rdata = s_r.vol;
          default: s_nxt.rdata = 32'h00000000;
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_r <= '0;
      s_r.ctrl <= `FAL_CTRL_RST;
    end
    else
      s_r <= s_nxt;
  end

  // -----------------------------------------------------------------
  // relay timers, one per channel
  // -----------------------------------------------------------------
  for (genvar g = 0; g < 4; g++)
  begin : g_tmr
    fal_alarm_timer u_tmr (
      .clk(clk),
      .rst(rst),
      .cond(s_r.light[g]),
      .tick(s_r.tick),
      .t1(s_r.cfg[g].t1),
      .t2(s_r.cfg[g].t2),
      .relay(tmr[g])
    );
  end

  // outputs, all from flops
  assign rdata = s_r.rdata;
  assign relay = s_r.relay;
  assign light = s_r.light;
  assign batch_state = s_r.bst;
  assign batch_vol = s_r.vol;
  assign freeze = s_r.frz;
  assign tot_clr = s_r.tclr;
  assign pcnt_clr = s_r.pcc;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !s_r.init);

  sequence s_run_pressed;
    s_r.bst == B_RUN && bev;
  endsequence

  a_batch_start:
    assert property (s_r.bst == B_IDLE && bev |=> s_r.bst == B_RUN)
    else $error("batch did not start");
  a_batch_hold:
    assert property (s_run_pressed and !s_r.ctrl.manual && bfound
                     |=> s_r.bst == B_HOLD && !s_r.relay[bch])
    else $error("batch not held or relay still on");
  a_batch_done:
    assert property (s_r.bst == B_RUN && !bev && reach
                     |=> s_r.bst == B_DONE && pcnt_clr ##1 !pcnt_clr)
    else $error("batch end missed");
  a_batch_new:
    assert property (s_r.bst == B_DONE && bev |=> s_r.bst == B_RUN && s_r.vol == 32'h0)
    else $error("new batch not cleared");
  a_sp_locked:
    assert property (bus.wr && bus.addr[7:6] == `FAL_CH_BASE && bus.addr[3:2] == `FAL_CH_SP
                     && s_r.cfg[bus.addr[5:4]].fn == FN_BATCH && s_r.bst == B_HOLD
                     |=> $stable(s_r.cfg))
    else $error("batch setpoint changed");
  a_manual_relay:
    assert property (s_r.ctrl.manual |=> relay == $past(s_r.man))
    else $error("manual relay value ignored");
  a_minmax_clear:
    assert property (mmclr |=> s_r.mn == 16'h0 && s_r.mx == 16'h0)
    else $error("min/max not cleared");
  a_edge_once:
    assert property (kev |=> !kev)
    else $error("one press gave two edges");
  a_tick_gap:
    assert property (s_r.tick |=> !s_r.tick)
    else $error("tick longer than one cycle");
endmodule // fal_top

// File: dv/fal_front_model.sv
// flow front end, function key and digital input model
`timescale 1ns/1ps
module fal_front_model
(
  input wire logic clk,
  output logic [15:0] flow,
  output logic flow_valid,
  output logic loop_open,
  output logic key_pin,
  output logic di_pin
);
  // sensor intact, nothing pressed at power-up
  initial
  begin
    flow = 16'h0000;
    flow_valid = 1'b0;
    loop_open = 1'b0;
    key_pin = 1'b0;
    di_pin = 1'b0;
  end
  // new instantaneous reading, held until the next one
  task set_flow(input logic [15:0] v);
    @(posedge clk);
    flow <= v;
    flow_valid <= 1'b1;
    @(posedge clk);
    flow_valid <= 1'b0;
  endtask
  // one press: long enough for the sync stages, then a full release
  task press(input logic use_di);
    @(posedge clk);
    if (use_di)
      di_pin <= 1'b1;
    else
      key_pin <= 1'b1;
    repeat (6) @(posedge clk);
    key_pin <= 1'b0;
    di_pin <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule // fal_front_model

// File: dv/fal_top_tb_top.sv
// self-checking bench of the flow alarm unit
`timescale 1ns/1ps
module fal_top_tb_top;
  import fal_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  fal_bus_t bus = '0;
  logic [31:0] rdata;
  logic [15:0] flow;
  logic flow_valid, loop_open, key_pin, di_pin, freeze, tot_clr, pcnt_clr;
  logic [3:0] relay, light;
  logic bro = 1'b1; // batch reset on power
  fal_bst_t sbst = B_IDLE; // batch state to restore
  logic [31:0] svol = 32'h0000_0000; // batch volume to restore
  int n_tclr = 0; // totalizer clear pulses seen
  int n_pcc = 0; // pulse counter clear pulses seen
  fal_bst_t batch_state;
  logic [31:0] batch_vol;
  logic [31:0] exp_q[$]; // expected read data, oldest first
  logic rd_d = 1'b0;
  logic [7:0] lf = 8'h18; // random state, starts at 24
  int fails = 0;
  int n_compared = 0;
  always #12.5 clk = ~clk;
  fal_front_model fal_front_model_i (.clk(clk), .flow(flow), .flow_valid(flow_valid),
    .loop_open(loop_open), .key_pin(key_pin), .di_pin(di_pin));
  fal_top #(.NCH(2), .TICK_CYCLES(10)) fal_top_i (.clk(clk), .rst(rst), .bus(bus),
    .rdata(rdata), .flow(flow), .flow_valid(flow_valid), .loop_open(loop_open),
    .key_pin(key_pin), .di_pin(di_pin), .batch_reset_on_power(bro), .saved_bst(sbst),
    .saved_vol(svol), .relay(relay), .light(light), .batch_state(batch_state),
    .batch_vol(batch_vol), .freeze(freeze), .tot_clr(tot_clr), .pcnt_clr(pcnt_clr));
  // -----------------------------------------------------------------
  // checking
  // -----------------------------------------------------------------
  task check(input string what, input logic [31:0] seen, input logic [31:0] expv);
    n_compared++;
    if (seen !== expv)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, expv, seen);
    end
  endtask
  task complete_run;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // read data stands only in the cycle after the strobe
  always @(posedge clk)
  begin
    if (rd_d)
      check("rdata", rdata, exp_q.pop_front());
    rd_d <= bus.rd;
    // one-cycle clear pulses are counted, not sampled
    n_tclr += (tot_clr === 1'b1);
    n_pcc += (pcnt_clr === 1'b1);
  end
  // -----------------------------------------------------------------
  // bus cycles
  // -----------------------------------------------------------------
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] expv);
    @(posedge clk);
    bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    exp_q.push_back(expv);
    @(posedge clk);
    bus.rd <= 1'b0;
  endtask
  // status word: lights, relays, batch state
  function automatic logic [31:0] st(logic [3:0] l, logic [3:0] r, logic [1:0] b);
    return {22'h0, b, r, l};
  endfunction
  // random source: one step of an 8-bit lfsr
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task flow_to(input logic [15:0] v);
    fal_front_model_i.set_flow(v);
    repeat (6) @(posedge clk);
  endtask
  initial
  begin
    #(25ns * 6000);
    fails++;
    complete_run();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rd(8'h00, 32'h0000_0000);
    rd(8'h3C, 32'h0000_0000);
    wr(8'h4C, 32'hFFFF_FFFF);
    rd(8'h4C, 32'h7D00_7D00);
    wr(8'h4C, 32'h0000_0000);
    wr(8'h44, 32'd100);
    wr(8'h48, 32'd10);
    wr(8'h40, 32'h3);
    wr(8'h54, 32'd50);
    wr(8'h50, 32'h2);
    flow_to(16'd150);
    rd(8'h08, st(4'h1, 4'h1, 2'h0));
    repeat (4)
    begin
      lf = lfsr(lf);
      flow_to(16'd91 + lf[2:0]);
      rd(8'h08, st(4'h1, 4'h1, 2'h0));
    end
    flow_to(16'd80);
    rd(8'h08, st(4'h0, 4'h0, 2'h0));
    // single pulse of two seconds on the over-limit channel
    wr(8'h4C, 32'h0000_0002);
    flow_to(16'd150);
    rd(8'h08, st(4'h1, 4'h1, 2'h0));
    repeat (40) @(posedge clk);
    rd(8'h08, st(4'h1, 4'h0, 2'h0));
    flow_to(16'd20);
    rd(8'h08, st(4'h2, 4'h2, 2'h0));
    // manual relays, key clears the totalizer meanwhile
    wr(8'h04, 32'h0000_0005);
    wr(8'h00, 32'h0000_0010);
    rd(8'h08, st(4'h2, 4'h5, 2'h0));
    check("light", light, 4'h2);
    fal_front_model_i.press(1'b0);
    // key clears min/max, input freezes
    wr(8'h00, 32'h0000_0006);
    rd(8'h08, st(4'h2, 4'h2, 2'h0));
    rd(8'h10, 32'h0000_0096);
    rd(8'h0C, 32'h0000_0014);
    fal_front_model_i.press(1'b0);
    rd(8'h10, 32'h0000_0000);
    fal_front_model_i.press(1'b1);
    check("frz", freeze, 1'b1);
    wr(8'h00, 32'hF);
    wr(8'h54, 32'd1000);
    wr(8'h50, 32'h4);
    flow_to(16'd0);
    fal_front_model_i.press(1'b0);
    check("bst", batch_state, B_RUN);
    check("relay", relay[1], 1'b1);
    fal_front_model_i.press(1'b1);
    check("bst", batch_state, B_HOLD);
    check("relay", relay[1], 1'b0);
    wr(8'h54, 32'd5);
    rd(8'h54, 32'd1000);
    fal_front_model_i.press(1'b0);
    flow_to(16'd200);
    repeat (100) @(posedge clk);
    check("bst", batch_state, B_DONE);
    check("relay", relay[1], 1'b0);
    flow_to(16'd0);
    fal_front_model_i.press(1'b0);
    check("bst", batch_state, B_RUN);
    check("vol", batch_vol, 32'h0000_0000);
    check("tclr", n_tclr, 1);
    check("pcc", n_pcc, 2);
    // second reset, batch restored in hold
    bro <= 1'b0;
    sbst <= B_HOLD;
    svol <= 32'h0000_1234;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    check("bst", batch_state, B_HOLD);
    check("vol", batch_vol, 32'h0000_1234);
    // open loop as aux input, blocking set but ignored
    wr(8'h00, 32'h0000_0040);
    wr(8'h40, 32'h0000_0009);
    fal_front_model_i.loop_open <= 1'b1;
    repeat (4) @(posedge clk);
    check("light", light, 4'h1);
    complete_run();
  end
endmodule // fal_top_tb_top
